// File: bench/pxi_pin_model.sv
// Purpose: pin side: outside drivers, pull-ups, open-drain pin0
// Assumes: bench changes ext_en/ext_lvl just after a clock edge
// Notes:   an undriven pin without pull-up flips each cycle, never a stale level
`timescale 1ns/1ps
module pxi_pin_model (
  input wire logic       ref_clk,
  input wire logic [3:0] ext_en,
  input wire logic [3:0] ext_lvl,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_pullup,
  output logic     [3:0] pin_in
);
  logic [3:0] flt = 4'h0;
  always_ff @(posedge ref_clk) flt <= ~pin_in;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_lvl[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = flt[i];
    end
  end
endmodule

// File: bench/pxi_port_irq_monitor.sv
// Purpose: port interrupt block checker
// Assumes: control bytes shadowed from bus writes
// Notes:   flags are set by hardware, so only control bits are trusted here
`timescale 1ns/1ps
`include "pxi_params.svh"
module pxi_port_irq_monitor (
  input wire logic              ref_clk,
  input wire logic              nrst,
  input wire logic [15:0]       addr,
  input wire logic [7:0]        wdata,
  input wire logic              wr_stb,
  input wire logic [3:0]        pin_in,
  input wire logic [3:0]        pin_out,
  input wire logic [3:0]        pin_oe,
  input wire logic [3:0]        pin_pullup,
  input wire logic              irq_accept,
  input wire logic [1:0]        sleep_mode,
  input wire pxi_pkg::pxi_evt_t evt,
  input wire logic              cap_lo_alt_sel,
  input wire logic              cap_lo_alt,
  input wire logic              pwm_hi_out,
  input wire logic              basetmr_tick,
  input wire logic              buzzer_pin
);
  import pxi_pkg::*;
  logic [7:0] s01, s23, srt, sp;
  logic       lvl_lo;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      {s01, s23, srt, sp} <= 32'h0;
    end else if (wr_stb) begin
      if (addr == `PXI_ADDR_IRQ01) s01 <= wdata;
      if (addr == `PXI_ADDR_IRQ23) s23 <= wdata;
      if (addr == `PXI_ADDR_ROUTE) srt <= wdata;
      if (addr == `PXI_ADDR_PORT) sp <= wdata;
    end
  end
  // low-level capture on pin0 with the short filter and no other owner
  assign lvl_lo = s01[2] & !s01[3] & srt[6] & !srt[1] & !cap_lo_alt_sel
                  & (sleep_mode == 2'h0) & !pin_in[0];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_od; pin_oe[0] |-> !pin_out[0]; endproperty
  a_od: assert property (p_od) else $error("pin0 driven high");
  property p_pull; (sp[0] & !sp[4] & sleep_mode == 2'h0)[*2] |-> pin_pullup[0]; endproperty
  a_pull: assert property (p_pull) else $error("pin0 pull-up off");
  property p_slp; sleep_mode != 2'h0 && $past(sleep_mode) != 2'h0 |-> !pin_pullup[0]; endproperty
  a_slp: assert property (p_slp) else $error("pull-up on in sleep");
  property p_acc; sleep_mode == 2'h1 && irq_accept |=> sleep_mode == 2'h0; endproperty
  a_acc: assert property (p_acc) else $error("accept did not resume");
  property p_buz; $past(nrst) && !srt[3] && !$past(srt[3]) |-> buzzer_pin == $past(pwm_hi_out);
  endproperty
  a_buz: assert property (p_buz) else $error("buzzer pin not pwm");
  property p_btk; (srt[5] ^ srt[4]) && $past(srt[5:4]) == srt[5:4] |-> basetmr_tick == srt[4];
  endproperty
  a_btk: assert property (p_btk) else $error("base tick wrong");
  property p_alt; cap_lo_alt_sel && $past(cap_lo_alt_sel) |-> evt.cap_lo == $past(cap_lo_alt);
  endproperty
  a_alt: assert property (p_alt) else $error("alt capture lost");
  property p_nowk; (!s23[0] && !s01[2] && !s01[6])[*3] |-> !evt.deep_wake; endproperty
  a_nowk: assert property (p_nowk) else $error("wake from edge mode");
  property p_lvc; lvl_lo[*8] |-> evt.cap_lo; endproperty
  a_lvc: assert property (p_lvc) else $error("level capture gap");
  c_wake: cover property (evt.deep_wake && sleep_mode == 2'h2);
  c_acc: cover property (sleep_mode == 2'h1 && irq_accept);
  c_lvc: cover property (lvl_lo[*8]);
endmodule

// File: bench/tb_pxi_port_irq.sv
// Purpose: self-checking bench of the port interrupt block
// Assumes: 25 ns clock; bench is the only bus master
// Notes:   flag reads use fixed waits longer than the pin path latency
`timescale 1ns/1ps
`include "pxi_params.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("Error t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_pxi_port_irq;
  import pxi_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, irq_accept = 1'b0;
  logic sleep_light_req = 1'b0, sleep_deep_req = 1'b0, cap_lo_alt_sel = 1'b0;
  logic cap_hi_alt_sel = 1'b0, cap_lo_alt = 1'b0, cap_hi_alt = 1'b0, subclk_tick = 1'b0;
  logic prescale_tick = 1'b0, pwm_hi_out = 1'b0, basetmr_tick, buzzer_pin, b;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [3:0]  pin_in, pin_out, pin_oe, pin_pullup, ext_en = 4'hF, ext_lvl = 4'hF;
  logic [1:0]  sleep_mode;
  pxi_evt_t    evt;
  int          failures = 0, checks_done = 0, n_lo, n_hi, n_ct, k;
  pxi_port_irq dut (.*);
  pxi_pin_model pins (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    pwm_hi_out <= ~pwm_hi_out;
    if (evt.cap_lo === 1'b1) n_lo++;
    if (evt.cap_hi === 1'b1) n_hi++;
    if (evt.count === 1'b1) n_ct++;
  end
  task automatic cyc(input int n); repeat (n) @(posedge ref_clk); endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {addr, wdata, wr_stb} <= {a, d, 1'b1};
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    {addr, rd_stb} <= {a, 1'b1};
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wait_mode(input logic [1:0] m);
    for (k = 0; k < 40 && sleep_mode !== m; k++) @(posedge ref_clk);
    `CHK(sleep_mode, m)
    if (k == 40) complete_run();
  endtask
  // one source, one mode: idle level first, then the active change
  task automatic src_case(input int p, input int s, input int m);
    logic [15:0] a;
    logic [7:0]  c, f;
    logic        st, lvl, fe;
    a = s < 2 ? `PXI_ADDR_IRQ01 : `PXI_ADDR_IRQ23;
    c = 8'(m << (2 + 4 * (s % 2)));
    f = 8'(2 << (4 * (s % 2)));
    st = s < 2 ? !m[1] : m == 1;
    lvl = s < 2 && m[0];
    fe = !(s >= 2 && m == 0);
    @(posedge ref_clk) ext_lvl[s] <= st;
    cyc(10);
    wr(a, c);
    cyc(2);
    #1 {n_lo, n_hi, n_ct} = '0;
    rd(a, c);
    @(posedge ref_clk) ext_lvl[s] <= !st;
    cyc(16);
    rd(a, fe ? c | f : c);
    `CHK(lvl ? int'(n_lo > 4) : n_lo, s == (p ? 0 : 2) ? int'(fe) : 0)
    `CHK(lvl ? int'(n_hi > 4) : n_hi, s == (p ? 1 : 3) ? int'(fe) : 0)
    `CHK(n_ct, s == (p ? 3 : 2) ? int'(fe) : 0)
    wr(a, 8'h00);
  endtask
  initial begin
    cyc(3);
    nrst <= 1'b1;
    // pins need three sync stages and the filter before they read back
    cyc(6);
    rd(`PXI_ADDR_PORT, 8'h0F);
    wr(16'hFE60, 8'hFF);
    for (int i = 1; i < 5; i++) rd(16'hFE5C + 16'(i), 8'h00);
    wr(`PXI_ADDR_ROUTE, 8'h5A);
    rd(`PXI_ADDR_ROUTE, 8'h5A);
    $display("register test done");
    for (int p = 0; p < 2; p++) begin
      wr(`PXI_ADDR_ROUTE, p ? 8'hD1 : 8'h10);
      for (int s = 0; s < 4; s++) for (int m = 0; m < 4; m++) src_case(p, s, m);
      $display("source pass %0d done", p);
    end
    @(posedge ref_clk) ext_lvl <= 4'hF;
    wr(`PXI_ADDR_PORT, 8'h10);
    cyc(2);
    `CHK({pin_oe[0], pin_out[0]}, 2'b10)
    wr(`PXI_ADDR_PORT, 8'h11);
    cyc(2);
    `CHK(pin_oe[0], 1'b0)
    wr(`PXI_ADDR_PORT, 8'h01);
    cyc(2);
    `CHK(pin_pullup[0], 1'b1)
    wr(`PXI_ADDR_IRQ01, 8'h05);
    @(posedge ref_clk) sleep_deep_req <= 1'b1;
    @(posedge ref_clk) sleep_deep_req <= 1'b0;
    cyc(2);
    `CHK(sleep_mode, PXI_DEEP)
    `CHK(pin_pullup[0], 1'b0)
    @(posedge ref_clk) ext_lvl[0] <= 1'b0;
    wait_mode(PXI_LIGHT);
    `CHK(evt.req[0], 1'b1)
    @(posedge ref_clk) irq_accept <= 1'b1;
    @(posedge ref_clk) irq_accept <= 1'b0;
    #1 `CHK(sleep_mode, PXI_RUN)
    @(posedge ref_clk) ext_lvl[0] <= 1'b1;
    wr(`PXI_ADDR_IRQ01, 8'h00);
    // pin2 latched high at deep entry: a rising edge must not set the flag
    wr(`PXI_ADDR_IRQ23, 8'h09);
    @(posedge ref_clk) sleep_deep_req <= 1'b1;
    @(posedge ref_clk) sleep_deep_req <= 1'b0;
    @(posedge ref_clk) ext_lvl[2] <= 1'b0;
    cyc(10);
    @(posedge ref_clk) ext_lvl[2] <= 1'b1;
    cyc(10);
    rd(`PXI_ADDR_IRQ23, 8'h09);
    wr(`PXI_ADDR_IRQ23, 8'h0D);
    @(posedge ref_clk) ext_lvl[2] <= 1'b0;
    wait_mode(PXI_LIGHT);
    `CHK(evt.req[2], 1'b1)
    @(posedge ref_clk) irq_accept <= 1'b1;
    @(posedge ref_clk) irq_accept <= 1'b0;
    #1 `CHK(sleep_mode, PXI_RUN)
    wr(`PXI_ADDR_IRQ23, 8'h00);
    $display("sleep test done");
    wr(`PXI_ADDR_ROUTE, 8'h18);
    cyc(4);
    k = 0;
    repeat (64) begin
      b = buzzer_pin;
      @(posedge ref_clk);
      #1 k += int'(buzzer_pin !== b);
    end
    `CHK(k, 16)
    wr(`PXI_ADDR_ROUTE, 8'h20);
    cyc(4);
    @(posedge ref_clk) cap_lo_alt_sel <= 1'b1;
    repeat (6) @(posedge ref_clk) cap_lo_alt <= !cap_lo_alt;
    @(posedge ref_clk) cap_lo_alt_sel <= 1'b0;
    $display("route test done");
    // a 20-cycle glitch must not pass the 32-cycle filter
    wr(`PXI_ADDR_ROUTE, 8'h06);
    wr(`PXI_ADDR_IRQ01, 8'h00);
    @(posedge ref_clk) ext_lvl[0] <= 1'b0;
    cyc(20);
    @(posedge ref_clk) ext_lvl[0] <= 1'b1;
    cyc(40);
    rd(`PXI_ADDR_IRQ01, 8'h00);
    @(posedge ref_clk) ext_lvl[0] <= 1'b0;
    cyc(45);
    rd(`PXI_ADDR_IRQ01, 8'h02);
    $display("filter test done");
    complete_run();
  end
  initial begin
    #1000000;
    failures++;
    complete_run();
  end
endmodule
bind pxi_port_irq pxi_port_irq_monitor mon (.*);

// File: verilog/pxi_params.svh
// Purpose: offsets, reset values, vector addresses and timing counts of the port interrupt block
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   included by the design module, the bench and the monitor
`ifndef PXI_PARAMS_SVH
`define PXI_PARAMS_SVH
`define PXI_ADDR_IRQ01      16'hFE5D
`define PXI_ADDR_IRQ23      16'hFE5E
`define PXI_ADDR_ROUTE      16'hFE5F
`define PXI_ADDR_PORT       16'hFE5C
`define PXI_RST_BYTE        8'h00
`define PXI_TCYC_NS         25
`define PXI_FILT_LONG_TCYC  128
`define PXI_FILT_MID_TCYC   32
`define PXI_FILT_LONG_CYC   ((`PXI_FILT_LONG_TCYC * `PXI_TCYC_NS) / `PXI_TCYC_NS)
`define PXI_FILT_MID_CYC    ((`PXI_FILT_MID_TCYC * `PXI_TCYC_NS) / `PXI_TCYC_NS)
`define PXI_VEC_SRC0        16'h0003
`define PXI_VEC_SRC1        16'h000B
`define PXI_VEC_SRC2        16'h0013
`define PXI_VEC_SRC3        16'h001B
`define PXI_BUZ_DIV         8
`endif

// File: verilog/pxi_pkg.sv
// Purpose: types of the port interrupt block
// Assumes: nothing
// Notes:   field layout follows the register bit order, msb first
package pxi_pkg;
  typedef struct packed {
    logic src1_polarity;
    logic src1_level_sel;
    logic src1_flag;
    logic src1_req_en;
    logic src0_polarity;
    logic src0_level_sel;
    logic src0_flag;
    logic src0_req_en;
  } pxi_irq01_t;
  typedef struct packed {
    logic src3_rise_en;
    logic src3_fall_en;
    logic src3_flag;
    logic src3_req_en;
    logic src2_rise_en;
    logic src2_fall_en;
    logic src2_flag;
    logic src2_req_en;
  } pxi_irq23_t;
  typedef struct packed {
    logic cap_hi_src_sel;
    logic cap_lo_src_sel;
    logic basetmr_clk_sel_hi;
    logic basetmr_clk_sel_lo;
    logic buzzer_route_sel;
    logic filter_const_sel;
    logic filter_const_on;
    logic count_src_sel;
  } pxi_route_t;
  typedef struct packed {
    logic [3:0] dir;
    logic [3:0] out_bit;
  } pxi_port_t;
  typedef struct packed {
    logic [3:0] req;
    logic       deep_wake;
    logic       cap_hi;
    logic       cap_lo;
    logic       count;
  } pxi_evt_t;
  typedef enum logic [1:0] {PXI_RUN, PXI_LIGHT, PXI_DEEP} pxi_mode_t;
endpackage

// File: verilog/pxi_port_irq.sv
// What this block does
// RL1 - pin0 output: low for 0, open for 1
// RL2 - pin0 data bit switches its pull-up
// RL3 - source1 condition from polarity and level bits
// RL4 - source0 condition from polarity and level bits
// RL5 - source1 flag and enable: wake, vector 000B
// RL6 - source0 flag and enable: wake, vector 0003
// RL7 - flags cleared only by software writes
// RL8 - sources 0/1 wake only in level mode
// RL9 - source3 edge select, vector 001B, no wake
// RL10 - source2 edge select, wake, vector 0013
// RL11 - deep sleep ignores edges toward latched pin2 state
// RL12 - software should use both edges on pin2
// RL13 - high capture from pin1 or pin3
// RL14 - level capture pulses every cycle
// RL15 - low capture from pin0 or pin2
// RL16 - base timer clock selection, 10 forbidden
// RL17 - buzzer route: base clock/8 or pwm high
// RL18 - noise filter constant 1, 128 or 32
// RL19 - count clock from pin3 or pin2
// RL20 - capture from other sources overrides port
// RL21 - sleep turns pin0 pull-up off, others hold
// RL22 - deep wake goes to light sleep until accepted
// RL23 - filtered samples compared for edges
// RL24 - level mode sets flags every cycle
// Purpose: external interrupt detection and input routing for a four-pin port
// Assumes: 40 MHz ref_clk is the cycle clock; pins are asynchronous
// Notes:   reads return data one cycle after the strobe; unmapped reads give 00
`timescale 1ns/1ps
module pxi_port_irq (
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  input  wire logic [15:0]         addr,
  input  wire logic [7:0]          wdata,
  input  wire logic                wr_stb,
  input  wire logic                rd_stb,
  output logic      [7:0]          rdata,
  input  wire logic [3:0]          pin_in,
  output logic      [3:0]          pin_out,
  output logic      [3:0]          pin_oe,
  output logic      [3:0]          pin_pullup,
  input  wire logic                sleep_light_req,
  input  wire logic                sleep_deep_req,
  input  wire logic                irq_accept,
  output logic      [1:0]          sleep_mode,
  output pxi_pkg::pxi_evt_t        evt,
  input  wire logic                cap_lo_alt_sel,
  input  wire logic                cap_hi_alt_sel,
  input  wire logic                cap_lo_alt,
  input  wire logic                cap_hi_alt,
  input  wire logic                subclk_tick,
  input  wire logic                prescale_tick,
  input  wire logic                pwm_hi_out,
  output logic                     basetmr_tick,
  output logic                     buzzer_pin
);
  import pxi_pkg::*;
  `include "pxi_params.svh"

  localparam int LONG_CYC = `PXI_FILT_LONG_CYC;
  localparam int MID_CYC  = `PXI_FILT_MID_CYC;
  localparam int DIV_HALF = `PXI_BUZ_DIV / 2;

  initial begin
    if (LONG_CYC < 1 || LONG_CYC > 255 || MID_CYC < 1 || DIV_HALF < 1) begin
      $error("filter or divider count out of range");
    end
  end

  pxi_irq01_t irq01_reg, irq01_next;
  pxi_irq23_t irq23_reg, irq23_next;
  pxi_route_t route_reg, route_next;
  pxi_port_t  port_reg, port_next;
  logic [7:0] rdata_next;

  logic [3:0] sync1_reg, sync2_reg, sync3_reg;
  logic [3:0] filt_reg, filt_next, prev_reg, prev_next;
  logic [7:0] fcnt_reg [4];
  logic [7:0] fcnt_next [4];
  logic [7:0] flim;

  pxi_mode_t  mode_reg, mode_next;
  logic       p2_latch_reg, p2_latch_next;

  logic [3:0] pin_out_next, pin_oe_next, pin_pullup_next;
  pxi_evt_t   evt_next;
  logic [2:0] div_reg, div_next;
  logic       buz_reg, buz_next;
  logic       btick_next, buzzer_next;

  logic [3:0] rise, fall;
  logic       hit0, hit1, hit2, hit3, lvl0, lvl1, bt_src;

  // noise filter: a pin change is taken once stable for the selected constant
  always_comb begin
    case ({route_reg.filter_const_sel, route_reg.filter_const_on}) // RL18
      2'b01:   flim = 8'(LONG_CYC - 1);
      2'b11:   flim = 8'(MID_CYC - 1);
      default: flim = 8'h00;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_filt
      always_comb begin
        fcnt_next[g] = 8'h00;
        filt_next[g] = filt_reg[g];
        // second and third stage agree before the change is counted
        if (sync2_reg[g] == sync3_reg[g] && sync3_reg[g] != filt_reg[g]) begin
          if (fcnt_reg[g] >= flim) begin
            filt_next[g] = sync3_reg[g];
          end else begin
            fcnt_next[g] = fcnt_reg[g] + 8'h01;
          end
        end
      end
      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          fcnt_reg[g] <= 8'h00;
        end else begin
          fcnt_reg[g] <= fcnt_next[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // edges from the filtered sample against the one before
  always_comb begin
    prev_next = filt_reg; // RL23
    rise = filt_reg & ~prev_reg; // RL23
    fall = ~filt_reg & prev_reg;
  end

  // detection conditions per source
  always_comb begin
    lvl0 = irq01_reg.src0_level_sel;
    lvl1 = irq01_reg.src1_level_sel;
    hit0 = lvl0 ? (filt_reg[0] == irq01_reg.src0_polarity) // RL4 RL24
                : (irq01_reg.src0_polarity ? rise[0] : fall[0]);
    hit1 = lvl1 ? (filt_reg[1] == irq01_reg.src1_polarity) // RL3 RL24
                : (irq01_reg.src1_polarity ? rise[1] : fall[1]);
    hit2 = (irq23_reg.src2_rise_en & rise[2]) | (irq23_reg.src2_fall_en & fall[2]); // RL10
    // edges toward the state latched at deep-sleep entry do not count
    if (mode_reg == PXI_DEEP) begin
      hit2 = (irq23_reg.src2_rise_en & rise[2] & ~p2_latch_reg) // RL11
           | (irq23_reg.src2_fall_en & fall[2] & p2_latch_reg);
    end
    hit3 = (irq23_reg.src3_rise_en & rise[3]) | (irq23_reg.src3_fall_en & fall[3]); // RL9
  end

  // register file; a hardware set wins over a software clear in the same cycle
  always_comb begin
    irq01_next = irq01_reg;
    irq23_next = irq23_reg;
    route_next = route_reg;
    port_next  = port_reg;
    rdata_next = `PXI_RST_BYTE;
    if (wr_stb) begin
      case (addr)
        `PXI_ADDR_IRQ01: irq01_next = pxi_irq01_t'(wdata);
        `PXI_ADDR_IRQ23: irq23_next = pxi_irq23_t'(wdata);
        `PXI_ADDR_ROUTE: route_next = pxi_route_t'(wdata);
        `PXI_ADDR_PORT:  port_next  = pxi_port_t'(wdata);
        default:         ;
      endcase
    end
    if (hit0) irq01_next.src0_flag = 1'b1; // RL6 RL7
    if (hit1) irq01_next.src1_flag = 1'b1; // RL5 RL7
    if (hit2) irq23_next.src2_flag = 1'b1; // RL10 RL7
    if (hit3) irq23_next.src3_flag = 1'b1; // RL9 RL7
    if (rd_stb) begin
      case (addr)
        `PXI_ADDR_IRQ01: rdata_next = irq01_reg;
        `PXI_ADDR_IRQ23: rdata_next = irq23_reg;
        `PXI_ADDR_ROUTE: rdata_next = route_reg;
        // data bits read back the filtered pins
        `PXI_ADDR_PORT:  rdata_next = {port_reg.dir, filt_reg};
        default:         rdata_next = `PXI_RST_BYTE;
      endcase
    end
  end

  // requests, wake and routed timer events
  always_comb begin
    evt_next.req[0] = irq01_reg.src0_flag & irq01_reg.src0_req_en; // RL6
    evt_next.req[1] = irq01_reg.src1_flag & irq01_reg.src1_req_en; // RL5
    evt_next.req[2] = irq23_reg.src2_flag & irq23_reg.src2_req_en; // RL10
    evt_next.req[3] = irq23_reg.src3_flag & irq23_reg.src3_req_en; // RL9
    evt_next.deep_wake = (evt_next.req[0] & lvl0) | (evt_next.req[1] & lvl1) // RL8
                       | evt_next.req[2];
    // level mode gives one capture per cycle while the level stands
    evt_next.cap_hi = cap_hi_alt_sel ? cap_hi_alt // RL20
                    : (route_reg.cap_hi_src_sel ? hit1 : hit3); // RL13 RL14
    evt_next.cap_lo = cap_lo_alt_sel ? cap_lo_alt // RL20
                    : (route_reg.cap_lo_src_sel ? hit0 : hit2); // RL15 RL14
    evt_next.count  = route_reg.count_src_sel ? hit3 : hit2; // RL19
  end

  // sleep mode tracking
  always_comb begin
    mode_next     = mode_reg;
    p2_latch_next = p2_latch_reg;
    case (mode_reg)
      PXI_RUN: begin
        if (sleep_deep_req) begin
          mode_next     = PXI_DEEP;
          p2_latch_next = filt_reg[2]; // RL11
        end else if (sleep_light_req) begin
          mode_next = PXI_LIGHT;
        end
      end
      PXI_DEEP: begin
        if (evt.deep_wake) mode_next = PXI_LIGHT; // RL22
      end
      PXI_LIGHT: begin
        if (irq_accept) mode_next = PXI_RUN; // RL22
      end
      default: mode_next = PXI_RUN;
    endcase
  end

  // pins: pin0 open drain, others push-pull
  always_comb begin
    pin_out_next    = port_reg.out_bit;
    pin_oe_next     = port_reg.dir;
    pin_out_next[0] = 1'b0; // RL1
    pin_oe_next[0]  = port_reg.dir[0] & ~port_reg.out_bit[0]; // RL1
    pin_pullup_next = port_reg.out_bit; // RL2
    // sleep drops only the pin0 pull-up; other pins keep their drive
    if (mode_reg != PXI_RUN) pin_pullup_next[0] = 1'b0; // RL21
  end

  // base timer clock and buzzer divider
  always_comb begin
    case ({route_reg.basetmr_clk_sel_hi, route_reg.basetmr_clk_sel_lo}) // RL16
      2'b00:   bt_src = subclk_tick;
      2'b01:   bt_src = 1'b1;
      2'b11:   bt_src = prescale_tick;
      default: bt_src = 1'b0; // forbidden setting stops the base clock
    endcase
    btick_next = bt_src;
    div_next   = div_reg;
    buz_next   = buz_reg;
    if (bt_src) begin
      if (div_reg == 3'(DIV_HALF - 1)) begin
        div_next = 3'h0;
        buz_next = ~buz_reg;
      end else begin
        div_next = div_reg + 3'h1;
      end
    end
    // pwm high is forced high by the buzzer select outside this block
    buzzer_next = route_reg.buzzer_route_sel ? buz_reg : pwm_hi_out; // RL17
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq01_reg    <= pxi_irq01_t'(`PXI_RST_BYTE);
      irq23_reg    <= pxi_irq23_t'(`PXI_RST_BYTE);
      route_reg    <= pxi_route_t'(`PXI_RST_BYTE);
      port_reg     <= pxi_port_t'(`PXI_RST_BYTE);
      rdata        <= 8'h00;
      filt_reg     <= 4'h0;
      prev_reg     <= 4'h0;
      mode_reg     <= PXI_RUN;
      p2_latch_reg <= 1'b0;
      pin_out      <= 4'h0;
      pin_oe       <= 4'h0;
      pin_pullup   <= 4'h0;
      evt          <= '0;
      div_reg      <= 3'h0;
      buz_reg      <= 1'b1;
      basetmr_tick <= 1'b0;
      buzzer_pin   <= 1'b1;
    end else begin
      irq01_reg    <= irq01_next;
      irq23_reg    <= irq23_next;
      route_reg    <= route_next;
      port_reg     <= port_next;
      rdata        <= rdata_next;
      filt_reg     <= filt_next;
      prev_reg     <= prev_next;
      mode_reg     <= mode_next;
      p2_latch_reg <= p2_latch_next;
      pin_out      <= pin_out_next;
      pin_oe       <= pin_oe_next;
      pin_pullup   <= pin_pullup_next;
      evt          <= evt_next;
      div_reg      <= div_next;
      buz_reg      <= buz_next;
      basetmr_tick <= btick_next;
      buzzer_pin   <= buzzer_next;
    end
  end

  always_comb sleep_mode = mode_reg;
endmodule
